// [cmp_pkg.sv]
package cmp_pkg;

    // ******************************************************************
    // bus geometry
    // ******************************************************************
    localparam int          AXI_AW        = 8;
    localparam int          AXI_DW        = 32;
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_MUX      = 8'h04;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ******************************************************************
    // control and status word layout
    // ******************************************************************
    localparam int          BIT_DISABLE   = 7;
    localparam int          BIT_BANDGAP   = 6;
    localparam int          BIT_OUTPUT    = 5;
    localparam int          BIT_FLAG      = 4;
    localparam int          BIT_IRQ_EN    = 3;
    localparam int          BIT_CAPTURE   = 2;
    localparam int          BIT_MODE_HI   = 1;
    localparam int          BIT_MODE_LO   = 0;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;

    // ******************************************************************
    // negative input mux word layout
    // ******************************************************************
    localparam int          BIT_MUX_EN    = 3;
    localparam int          BIT_SEL_HI    = 2;
    localparam int          BIT_SEL_LO    = 0;
    localparam logic [3:0]  MUX_RESET     = 4'h0;

    // ******************************************************************
    // interrupt modes
    // ******************************************************************
    localparam logic [1:0]  MODE_TOGGLE   = 2'h0;
    localparam logic [1:0]  MODE_RSVD     = 2'h1;
    localparam logic [1:0]  MODE_FALL     = 2'h2;
    localparam logic [1:0]  MODE_RISE     = 2'h3;

    typedef logic [1:0] cmp_mode_t;

    // true when the present/previous output pair matches the mode
    function automatic logic cmpModeHit(input cmp_mode_t mode,
                                        input logic      cur,
                                        input logic      prev);
        logic hit;
        hit = 1'b0;
        case (mode)
            MODE_TOGGLE: hit = cur ^ prev;
            MODE_FALL:   hit = prev & ~cur;
            MODE_RISE:   hit = cur & ~prev;
            default:     hit = 1'b0;
        endcase
        return hit;
    endfunction

endpackage

// [cmp_evt_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface cmp_evt_if;
    logic [1:0] mode;
    logic       rawIn;
    logic       syncOut;
    logic       prevOut;
    logic       evtHit;

    modport det (
        input  mode,
        input  rawIn,
        output syncOut,
        output prevOut,
        output evtHit
    );

    modport ctrl (
        output mode,
        output rawIn,
        input  syncOut,
        input  prevOut,
        input  evtHit
    );
endinterface

`default_nettype wire

// [cmp_edge_det.sv]
`timescale 1ns/10ps
`default_nettype none

module cmp_edge_det
    import cmp_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // towards the control logic
    cmp_evt_if.det    evt
);

    logic syncMeta;
    logic syncStage;
    logic prevStage;

    // ******************************************************************
    // synchroniser and edge history
    // ******************************************************************
    // syncMeta feeds syncStage only; it may be metastable
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            syncMeta  <= 1'b0;
            syncStage <= 1'b0;
            prevStage <= 1'b0;
        end else begin
            syncMeta  <= evt.rawIn;
            syncStage <= syncMeta;                                       // RULE2
            prevStage <= syncStage;                                      // RULE13
        end
    end

    assign evt.syncOut = syncStage;
    assign evt.prevOut = prevStage;
    // reserved mode never hits
    assign evt.evtHit  = cmpModeHit(evt.mode, syncStage, prevStage); // RULE8 RULE13

endmodule

`default_nettype wire

// [cmp_event_ctrl.sv]
// Functional notes
// [RULE1] Bandgap select high routes the internal reference to the plus input, low the plus pin.
// [RULE2] The raw comparator result is synchronised, adding one to two clocks, then readable.
// [RULE3] The flag sets whenever the synchronised output shows the event chosen by the mode.
// [RULE4] The flag clears when its vector is taken or when software writes a one to it.
// [RULE5] An interrupt is requested only while flag, local enable and global enable are all one.
// [RULE6] Capture routing high feeds the comparator output to the timer capture trigger, else none.
// [RULE7] The routed output goes through the capture noise canceller and edge select like a pin.
// [RULE8] Mode 00 is toggle, 01 reserved, 10 falling edge and 11 rising edge.
// [RULE9] Software clears the local enable before changing the mode to avoid a spurious interrupt.
// [RULE10] Mux enable high with converter off drives the minus input from converter pin N.
// [RULE11] Mux enable low or converter on drives the minus input from the dedicated minus pin.
// [RULE12] The disable bit switches the comparator off; software clears the enable first.
// [RULE13] Edges come from present versus previous synchronised output; reserved never sets the flag.
`timescale 1ns/10ps
`default_nettype none

module cmp_event_ctrl
    import cmp_pkg::*;
(
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    // axi4-lite write address and data
    input  wire logic [cmp_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [cmp_pkg::AXI_DW-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // axi4-lite read
    input  wire logic [cmp_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [cmp_pkg::AXI_DW-1:0]      s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // analog front end and system
    input  wire logic                       compRaw,
    input  wire logic                       converterEnable,
    input  wire logic                       globalIrqEnable,
    input  wire logic                       vectorTaken,
    // analog controls
    output logic                            bandgapSelect,
    output logic                            comparatorDisable,
    output logic                            negUsePin,
    output logic [2:0]                      negChannel,
    // event outputs
    output logic                            captureTrigger,
    output logic                            irqRequest
);

    // ******************************************************************
    // state
    // ******************************************************************
    logic [7:0]  ctrl;
    logic [3:0]  muxCtrl;
    logic        flag;

    cmp_evt_if evtBus ();

    cmp_edge_det u_det (
        .core_clk (core_clk),
        .nrst     (nrst),
        .evt      (evtBus.det)
    );

    assign evtBus.mode  = ctrl[BIT_MODE_HI:BIT_MODE_LO];
    assign evtBus.rawIn = compRaw;

    // ******************************************************************
    // bus decode
    // ******************************************************************
    wire         wrAccept  = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
    wire         wrFire    = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    wire         wrCtrl    = s_axi_awaddr == ADDR_CTRL;
    wire         wrMux     = s_axi_awaddr == ADDR_MUX;
    wire         wrLane0   = wrFire & s_axi_wstrb[0];
    wire         ctrlWe    = wrLane0 & wrCtrl;
    wire         muxWe     = wrLane0 & wrMux;
    wire         rdAccept  = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    wire         rdFire    = s_axi_arvalid & s_axi_arready;
    wire         rdCtrl    = s_axi_araddr == ADDR_CTRL;
    wire         rdMux     = s_axi_araddr == ADDR_MUX;
    wire [7:0]   wByte     = s_axi_wdata[7:0];

    // read view: output bit and flag are live state
    wire [7:0]   ctrlView  = {ctrl[BIT_DISABLE], ctrl[BIT_BANDGAP], evtBus.syncOut, flag,
                              ctrl[BIT_IRQ_EN], ctrl[BIT_CAPTURE],
                              ctrl[BIT_MODE_HI:BIT_MODE_LO]};                        // RULE2
    wire [31:0]  rdWord    = rdCtrl ? {24'h000000, ctrlView} :
                             rdMux  ? {28'h0000000, muxCtrl} : 32'h00000000;

    // ******************************************************************
    // flag and routing decode
    // ******************************************************************
    wire         flagSet   = evtBus.evtHit;                                          // RULE3
    wire         flagW1c   = ctrlWe & wByte[BIT_FLAG];                               // RULE4
    // a new event wins over a clear in the same cycle
    wire         next_flag = flagSet | (flag & ~vectorTaken & ~flagW1c);             // RULE4
    wire         next_irq  = next_flag & ctrl[BIT_IRQ_EN] & globalIrqEnable;         // RULE5
    wire         muxActive = muxCtrl[BIT_MUX_EN] & ~converterEnable;                 // RULE10
    // timer front end applies its own noise canceller and edge select
    wire         next_cap  = ctrl[BIT_CAPTURE] & evtBus.syncOut;                     // RULE6 RULE7

    // ******************************************************************
    // registers
    // ******************************************************************
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl    <= CTRL_RESET;
            muxCtrl <= MUX_RESET;
        end else begin
            if (ctrlWe) begin
                ctrl <= wByte;
            end
            if (muxWe) begin
                muxCtrl <= wByte[3:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    // outputs all registered so the analog side sees clean levels
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bandgapSelect     <= 1'b0;
            comparatorDisable <= 1'b0;
            negUsePin         <= 1'b1;
            negChannel        <= 3'h0;
            captureTrigger    <= 1'b0;
            irqRequest        <= 1'b0;
        end else begin
            bandgapSelect     <= ctrl[BIT_BANDGAP];                                  // RULE1
            comparatorDisable <= ctrl[BIT_DISABLE];                                  // RULE12
            negUsePin         <= ~muxActive;                                         // RULE11
            negChannel        <= muxCtrl[BIT_SEL_HI:BIT_SEL_LO];                     // RULE10
            captureTrigger    <= next_cap;                                           // RULE6
            irqRequest        <= next_irq;                                           // RULE5
        end
    end

    // ******************************************************************
    // axi4-lite handshakes
    // ******************************************************************
    // address and data are taken together, which costs one wait cycle
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= wrAccept;
            s_axi_wready  <= wrAccept;
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wrCtrl | wrMux) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= rdAccept;
            if (rdFire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdWord;
                s_axi_rresp  <= (rdCtrl | rdMux) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ******************************************************************
    // assertions
    // ******************************************************************
    sequence seqRawRise;
        !compRaw ##1 compRaw [*3];
    endsequence

    sequence seqSyncFall;
        evtBus.prevOut && !evtBus.syncOut;
    endsequence

    sequence seqW1cOnly;
        flagW1c && !flagSet;
    endsequence

    AST_BANDGAP: assert property (@(posedge core_clk) disable iff (!nrst)
        ctrlWe ##1 1'b1 |=> bandgapSelect == $past(wByte[BIT_BANDGAP], 2))  // RULE1
        else $error("bandgap select does not follow the written bit");

    AST_SYNC_LAT: assert property (@(posedge core_clk) disable iff (!nrst)
        seqRawRise |-> ##[0:1] evtBus.syncOut)  // RULE2
        else $error("synchronised output late after raw rise");

    AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (!nrst)
        evtBus.evtHit |=> flag)  // RULE3
        else $error("event did not set the flag");

    AST_FLAG_VEC_CLR: assert property (@(posedge core_clk) disable iff (!nrst)
        vectorTaken && !flagSet |=> !flag)  // RULE4
        else $error("vector taken did not clear the flag");

    AST_FLAG_W1C: assert property (@(posedge core_clk) disable iff (!nrst)
        seqW1cOnly |=> !flag)  // RULE4
        else $error("write one did not clear the flag");

    AST_IRQ_GATE: assert property (@(posedge core_clk) disable iff (!nrst)
        irqRequest |-> $past(ctrl[BIT_IRQ_EN]) && $past(globalIrqEnable) && flag)  // RULE5
        else $error("interrupt requested without flag and both enables");

    AST_IRQ_ON: assert property (@(posedge core_clk) disable iff (!nrst)
        flag && ctrl[BIT_IRQ_EN] && globalIrqEnable && !vectorTaken && !flagW1c
        |=> irqRequest)  // RULE5
        else $error("interrupt missing while flag and enables set");

    AST_CAPTURE: assert property (@(posedge core_clk) disable iff (!nrst)
        captureTrigger |-> $past(ctrl[BIT_CAPTURE]) && $past(evtBus.syncOut))  // RULE6
        else $error("capture trigger driven while routing off");

    AST_FALL: assert property (@(posedge core_clk) disable iff (!nrst)
        (evtBus.mode == MODE_FALL) ##0 seqSyncFall |=> flag)  // RULE8
        else $error("falling edge missed in falling mode");

    AST_RSVD: assert property (@(posedge core_clk) disable iff (!nrst)
        evtBus.mode == MODE_RSVD |-> !evtBus.evtHit)  // RULE13
        else $error("reserved mode produced an event");

    AST_NEG_PIN: assert property (@(posedge core_clk) disable iff (!nrst)
        !muxCtrl[BIT_MUX_EN] || converterEnable |=> negUsePin)  // RULE11
        else $error("minus input not on dedicated pin");

    AST_NEG_MUX: assert property (@(posedge core_clk) disable iff (!nrst)
        muxActive |=> !negUsePin && negChannel == $past(muxCtrl[BIT_SEL_HI:BIT_SEL_LO]))  // RULE10
        else $error("minus input not on selected converter pin");

    AST_DISABLE: assert property (@(posedge core_clk) disable iff (!nrst)
        comparatorDisable == $past(ctrl[BIT_DISABLE]))  // RULE12
        else $error("disable output does not follow its bit");

endmodule

`default_nettype wire

// [tb_comparator_event_control.sv]
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module tb_comparator_event_control;
    import cmp_pkg::*;

    logic        core_clk;
    logic        nrst;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        compRaw;
    logic        converterEnable;
    logic        globalIrqEnable;
    logic        vectorTaken;
    logic        bandgapSelect;
    logic        comparatorDisable;
    logic        negUsePin;
    logic [2:0]  negChannel;
    logic        captureTrigger;
    logic        irqRequest;
    int          mismatches;
    int          comparisons;
    logic [31:0] rd;

    cmp_event_ctrl uut (.core_clk(core_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .compRaw(compRaw), .converterEnable(converterEnable),
        .globalIrqEnable(globalIrqEnable), .vectorTaken(vectorTaken),
        .bandgapSelect(bandgapSelect), .comparatorDisable(comparatorDisable),
        .negUsePin(negUsePin), .negChannel(negChannel), .captureTrigger(captureTrigger),
        .irqRequest(irqRequest));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ******************************************************************
    // bus master tasks
    // ******************************************************************
    // address and data are released separately, each once its own ready is seen
    task automatic axiWrite(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                            input logic [1:0] expResp);
        int   n;
        logic awDone;
        logic wDone;
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        awDone = 1'b0;
        wDone = 1'b0;
        n = 0;
        while (!(awDone && wDone) && n < 100) begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready === 1'b1) begin
                awDone = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                wDone = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        s_axi_bready <= 1'b0;
        `CHK("bvalid", 1'b1, s_axi_bvalid)
        `CHK("bresp", expResp, s_axi_bresp)
        // registered outputs follow the written register one edge after the response
        @(posedge core_clk);
    endtask

    task automatic axiRead(input logic [7:0] a, input logic [1:0] expResp);
        int n;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        n = 0;
        while (s_axi_rvalid !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        `CHK("rvalid", 1'b1, s_axi_rvalid)
        `CHK("rresp", expResp, s_axi_rresp)
    endtask

    // raw change at one edge, then look between edges three edges later
    task automatic setRaw(input logic v);
        @(posedge core_clk);
        compRaw <= v;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // ******************************************************************
    // scenarios
    // ******************************************************************
    task automatic testReset;
        `CHK("negUsePin", 1'b1, negUsePin)
        `CHK("bandgap", 1'b0, bandgapSelect)
        `CHK("irqReq", 1'b0, irqRequest)
        axiRead(ADDR_CTRL, RESP_OKAY);
        `CHK("ctrlReset", {24'h0, CTRL_RESET}, rd)
        axiRead(ADDR_MUX, RESP_OKAY);
        `CHK("muxReset", {28'h0, MUX_RESET}, rd)
        axiRead(8'h08, RESP_SLVERR);
        `CHK("unmappedData", 32'h0, rd)
        axiWrite(8'h0C, 8'hFF, 4'hF, RESP_SLVERR);
        $display("test reset done");
    endtask

    task automatic testAnalogSel;
        axiWrite(ADDR_CTRL, 8'hC0, 4'hF, RESP_OKAY);
        `CHK("bandgapOn", 1'b1, bandgapSelect)
        `CHK("disableOn", 1'b1, comparatorDisable)
        axiRead(ADDR_CTRL, RESP_OKAY);
        `CHK("ctrlBack", 32'h0000_00C0, rd)
        axiWrite(ADDR_CTRL, 8'h00, 4'h0, RESP_OKAY);
        `CHK("strbOff", 1'b1, bandgapSelect)
        axiWrite(ADDR_CTRL, 8'h00, 4'hF, RESP_OKAY);
        `CHK("bandgapOff", 1'b0, bandgapSelect)
        `CHK("disableOff", 1'b0, comparatorDisable)
        $display("test analog select done");
    endtask

    task automatic testNegMux;
        for (int i = 0; i < 8; i++) begin
            converterEnable <= 1'b0;
            axiWrite(ADDR_MUX, 8'h08 | 8'(i), 4'hF, RESP_OKAY);
            `CHK("negPinMux", 1'b0, negUsePin)
            `CHK("negChannel", 3'(i), negChannel)
            converterEnable <= 1'b1;
            repeat (3) @(posedge core_clk);
            `CHK("negPinAdc", 1'b1, negUsePin)
        end
        converterEnable <= 1'b0;
        axiWrite(ADDR_MUX, 8'h05, 4'hF, RESP_OKAY);
        `CHK("negPinOff", 1'b1, negUsePin)
        $display("test negative mux done");
    endtask

    task automatic testModes;
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            axiWrite(ADDR_CTRL, {6'h0, m}, 4'hF, RESP_OKAY);
            setRaw(1'b1);
            repeat (3) @(posedge core_clk);
            axiRead(ADDR_CTRL, RESP_OKAY);
            `CHK("syncHigh", 1'b1, rd[BIT_OUTPUT])
            `CHK("flagRise", (m == MODE_TOGGLE || m == MODE_RISE), rd[BIT_FLAG])
            axiWrite(ADDR_CTRL, {6'h4, m}, 4'hF, RESP_OKAY);
            setRaw(1'b0);
            repeat (3) @(posedge core_clk);
            axiRead(ADDR_CTRL, RESP_OKAY);
            `CHK("syncLow", 1'b0, rd[BIT_OUTPUT])
            `CHK("flagFall", (m == MODE_TOGGLE || m == MODE_FALL), rd[BIT_FLAG])
            axiWrite(ADDR_CTRL, {6'h4, m}, 4'hF, RESP_OKAY);
            axiRead(ADDR_CTRL, RESP_OKAY);
            `CHK("flagW1c", 1'b0, rd[BIT_FLAG])
        end
        $display("test interrupt modes done");
    endtask

    task automatic testCapture;
        axiWrite(ADDR_CTRL, 8'h04, 4'hF, RESP_OKAY);
        setRaw(1'b1);
        `CHK("captureOn", 1'b1, captureTrigger)
        axiWrite(ADDR_CTRL, 8'h00, 4'hF, RESP_OKAY);
        `CHK("captureOff", 1'b0, captureTrigger)
        setRaw(1'b0);
        `CHK("captureQuiet", 1'b0, captureTrigger)
        axiWrite(ADDR_CTRL, 8'h10, 4'hF, RESP_OKAY);
        $display("test capture routing done");
    endtask

    task automatic testIrq;
        axiWrite(ADDR_CTRL, {6'h0, MODE_RISE}, 4'hF, RESP_OKAY);
        axiWrite(ADDR_CTRL, {6'h2, MODE_RISE}, 4'hF, RESP_OKAY);
        globalIrqEnable <= 1'b0;
        setRaw(1'b1);
        `CHK("irqNoGlobal", 1'b0, irqRequest)
        globalIrqEnable <= 1'b1;
        repeat (2) @(posedge core_clk);
        `CHK("irqAll", 1'b1, irqRequest)
        axiWrite(ADDR_CTRL, {6'h0, MODE_RISE}, 4'hF, RESP_OKAY);
        `CHK("irqNoLocal", 1'b0, irqRequest)
        axiRead(ADDR_CTRL, RESP_OKAY);
        `CHK("flagWriteZero", 1'b1, rd[BIT_FLAG])
        axiWrite(ADDR_CTRL, {6'h2, MODE_RISE}, 4'hF, RESP_OKAY);
        `CHK("irqAgain", 1'b1, irqRequest)
        @(posedge core_clk);
        vectorTaken <= 1'b1;
        @(posedge core_clk);
        vectorTaken <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK("irqVector", 1'b0, irqRequest)
        axiRead(ADDR_CTRL, RESP_OKAY);
        `CHK("flagVector", 1'b0, rd[BIT_FLAG])
        $display("test interrupt request done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ******************************************************************
    // main sequence and watchdog
    // ******************************************************************
    initial begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
        {compRaw, converterEnable, globalIrqEnable, vectorTaken} = '0;
        mismatches = 0;
        comparisons = 0;
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        testReset();
        testAnalogSel();
        testNegMux();
        testModes();
        testCapture();
        testIrq();
        print_verdict();
    end

    // the whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        print_verdict();
    end
endmodule

`default_nettype wire
